// [core/etc_timer.sv]
// eight bit timer with one compare unit, top level
// assumes all control bits arrive as plain ports synchronous to clock
//
// Behaviour
// - tick from io clock or crystal oscillator
// - each tick clears, counts up or down
// - zero tick source field stops counting
// - cpu counter write beats clear and count
// - top and bottom indications from count
// - mode bits pick sequence and overflow point
// - match sets compare flag on next tick
// - flag requests irq, cleared by ack or one
// - pwm modes buffer compare, update at max
// - cpu reaches buffer or active compare value
// - force strobe acts like match on the output outside pwm modes, no flag, no clear
// - counter write blocks match at next tick, except the mode two clear
// - output state kept across mode changes
// - output action takes effect immediately
// - nonzero action overrides port pin value
// - action zero leaves output state unchanged
// - normal mode counts up and wraps
// - normal overflow flag set when count wraps
// - action sets polarity or set/clear/toggle
// - mode two clears count on match
// - mode three runs zero to max, restarts
// - mode one counts up then down
`default_nettype none

module etc_timer #(
  parameter int unsigned W = 8 // counter width
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // tick sources
  input wire logic io_clock_tick,
  input wire logic crystal_pin_a,
  input wire logic crystal_pin_b,
  // configuration
  input wire logic async_clock_select,
  input wire logic [2:0] tick_source_field,
  input wire logic [1:0] waveform_mode_field,
  input wire logic [1:0] output_action_field,
  // counter access
  input wire logic count_wr,
  input wire logic [W-1:0] count_wdata,
  output logic [W-1:0] count_value,
  // compare access
  input wire logic compare_wr,
  input wire logic [W-1:0] compare_wdata,
  output logic [W-1:0] compare_rdata,
  // strobes
  input wire logic force_compare_strobe,
  // flags and interrupts
  input wire logic compare_irq_enable,
  input wire logic overflow_irq_enable,
  input wire logic compare_flag_w1c,
  input wire logic overflow_flag_w1c,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  output logic compare_match_flag,
  output logic overflow_flag,
  output logic compare_irq,
  output logic overflow_irq,
  // status
  output logic count_top,
  output logic count_bottom,
  // port pin
  input wire logic port_value,
  input wire logic port_dir,
  output logic pin_out,
  output logic pin_oe
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [1:0] sync; // reset release chain
  } etc_rst_s;

  typedef struct packed {
    logic [W-1:0] cnt; // counter
    logic down; // counting down (dual slope)
    logic blk; // match blocked until next tick
    logic ocf; // compare match flag
    logic tov; // overflow flag
    logic oc; // internal compare output state
    logic matched; // match seen, flag due next tick
  } etc_core_s;

  etc_rst_s rs_q, rs_d;
  etc_core_s st_q, st_d;
  logic rst_n; // synchronised reset
  logic tick; // selected timer tick
  logic [W-1:0] cmp; // active compare value
  logic is_pwm; // pwm mode
  logic at_top; // counter equals max
  logic at_bot; // counter equals zero
  logic match; // comparator result
  logic upd; // buffered compare update strobe
  logic pc_dn; // next dual slope step goes down

  // ************************************************
  // reset release
  // ************************************************
  // two flops so no state flop leaves reset on a marginal edge
  always_comb begin
    rs_d.sync = {rs_q.sync[0], 1'b1};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs_q <= '0;
    end else begin
      rs_q <= rs_d;
    end
  end

  assign rst_n = rs_q.sync[1];

  // ************************************************
  // submodules
  // ************************************************
  // second crystal pin is the oscillator return; only pin a is sampled
  etc_tick_sel u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .async_clock_select(async_clock_select),
    .tick_source_field(tick_source_field),
    .io_clock_tick(io_clock_tick),
    .crystal_pin_a(crystal_pin_a),
    .timer_tick(tick)
  );

  etc_compare #(.W(W)) u_cmp (
    .clock(clock),
    .rst_n(rst_n),
    .wr(compare_wr),
    .wdata(compare_wdata),
    .rdata(compare_rdata),
    .buffered(is_pwm),
    .update(upd),
    .compare_value(cmp)
  );

  // ************************************************
  // decode helpers
  // ************************************************
  // applies one output action to the current state
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    case (act)
      etc_pkg::COM_NONE: apply_action = cur;
      etc_pkg::COM_TOGGLE: apply_action = ~cur;
      etc_pkg::COM_CLEAR: apply_action = 1'b0;
      etc_pkg::COM_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction : apply_action

  assign is_pwm = (waveform_mode_field == etc_pkg::WGM_PC_PWM) ||
    (waveform_mode_field == etc_pkg::WGM_FAST_PWM);
  assign at_top = (st_q.cnt == etc_pkg::CNT_MAX);
  assign at_bot = (st_q.cnt == etc_pkg::CNT_BOTTOM);
  assign match = (st_q.cnt == cmp);
  // both pwm modes load on the tick that leaves max: fast pwm then
  // starts its bottom with the new value, phase correct its down slope
  assign upd = tick && (((waveform_mode_field == etc_pkg::WGM_FAST_PWM) && at_top) ||
    ((waveform_mode_field == etc_pkg::WGM_PC_PWM) && at_top));
  // dual slope turns at max and again once it has come down to bottom
  assign pc_dn = at_top || (st_q.down && !at_bot);

  // ************************************************
  // counter, flags and output state
  // ************************************************
  always_comb begin
    st_d = st_q;
    // flags: clears first, so a same cycle set wins
    if (compare_flag_w1c || compare_irq_ack) begin
      st_d.ocf = 1'b0;
    end
    if (overflow_flag_w1c || overflow_irq_ack) begin
      st_d.tov = 1'b0;
    end
    if (tick) begin
      // flag follows the match of the previous tick
      if (st_q.matched) begin
        st_d.ocf = 1'b1;
      end
      st_d.matched = match && !st_q.blk;
      st_d.blk = 1'b0;
      case (waveform_mode_field)
        etc_pkg::WGM_NORMAL: begin
          st_d.cnt = st_q.cnt + 1'b1;
          st_d.down = 1'b0;
          if (at_top) begin
            st_d.tov = 1'b1;
          end
        end
        etc_pkg::WGM_CTC: begin
          // a compare of max clears and overflows on one tick
          st_d.down = 1'b0;
          if (match) begin
            st_d.cnt = etc_pkg::CNT_BOTTOM;
          end else begin
            st_d.cnt = st_q.cnt + 1'b1;
          end
          if (at_top) begin
            st_d.tov = 1'b1;
          end
        end
        etc_pkg::WGM_FAST_PWM: begin
          st_d.down = 1'b0;
          if (at_top) begin
            st_d.cnt = etc_pkg::CNT_BOTTOM;
            st_d.tov = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + 1'b1;
          end
        end
        etc_pkg::WGM_PC_PWM: begin
          // down stays set on the bottom value so the wrap point is seen
          if (pc_dn) begin
            st_d.cnt = st_q.cnt - 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + 1'b1;
          end
          st_d.down = pc_dn;
          // overflow as the count leaves the bottom it came down to
          if (at_bot && st_q.down) begin
            st_d.tov = 1'b1;
          end
        end
        default: begin
          st_d.cnt = st_q.cnt;
        end
      endcase
      // output state: actions read live, never buffered
      if (match && !st_q.blk) begin
        case (waveform_mode_field)
          etc_pkg::WGM_FAST_PWM: begin
            if (output_action_field[1]) begin
              st_d.oc = output_action_field[0];
            end else begin
              st_d.oc = apply_action(output_action_field, st_q.oc);
            end
          end
          etc_pkg::WGM_PC_PWM: begin
            if (output_action_field[1]) begin
              // judged by the next step, so a match at max acts as downward
              st_d.oc = output_action_field[0] ^ pc_dn;
            end
          end
          default: begin
            st_d.oc = apply_action(output_action_field, st_q.oc);
          end
        endcase
      end else if ((waveform_mode_field == etc_pkg::WGM_FAST_PWM) && at_top &&
                   output_action_field[1]) begin
        st_d.oc = ~output_action_field[0];
      end
    end
    // forced compare in non-pwm modes: output only
    if (force_compare_strobe && !is_pwm) begin
      st_d.oc = apply_action(output_action_field, st_q.oc);
    end
    // cpu write wins over any count or clear
    // the overflow flag of this tick still stands; only the count is lost
    if (count_wr) begin
      st_d.cnt = count_wdata;
      st_d.blk = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign count_value = st_q.cnt;
  assign compare_match_flag = st_q.ocf;
  assign overflow_flag = st_q.tov;
  // enables only gate the requests; the flags stand regardless
  assign compare_irq = st_q.ocf && compare_irq_enable;
  assign overflow_irq = st_q.tov && overflow_irq_enable;
  assign count_top = at_top;
  assign count_bottom = at_bot;
  // pin override keeps the port's own direction
  assign pin_out = (output_action_field != etc_pkg::COM_NONE) ? st_q.oc : port_value;
  assign pin_oe = port_dir;

  logic unused_b;
  assign unused_b = crystal_pin_b;
endmodule : etc_timer

`default_nettype wire

// [include/etc_pkg.sv]
// package for the eight bit timer with one compare unit
// assumes a single 25 MHz clock domain and no register bus
`default_nettype none

package etc_pkg;
  // ************************************************
  // widths and fixed values
  // ************************************************
  localparam int unsigned CNT_W = 8; // counter width
  localparam logic [7:0] CNT_BOTTOM = 8'h00; // bottom of the count
  localparam logic [7:0] CNT_MAX = 8'hff; // maximum of the count
  localparam logic [7:0] RST_COUNT = 8'h00; // counter after reset
  localparam logic [7:0] RST_COMPARE = 8'h00; // compare value after reset
  localparam logic [1:0] RST_MODE = 2'h0; // waveform mode after reset
  localparam logic [1:0] RST_ACTION = 2'h0; // output action after reset
  localparam logic [2:0] RST_SOURCE = 3'h0; // tick source after reset

  // ************************************************
  // waveform modes
  // ************************************************
  localparam logic [1:0] WGM_NORMAL = 2'h0; // count up, wrap
  localparam logic [1:0] WGM_PC_PWM = 2'h1; // dual slope pwm
  localparam logic [1:0] WGM_CTC = 2'h2; // clear on match
  localparam logic [1:0] WGM_FAST_PWM = 2'h3; // single slope pwm

  // ************************************************
  // output actions
  // ************************************************
  localparam logic [1:0] COM_NONE = 2'h0; // no change
  localparam logic [1:0] COM_TOGGLE = 2'h1; // toggle on match
  localparam logic [1:0] COM_CLEAR = 2'h2; // clear (non-inverted pwm)
  localparam logic [1:0] COM_SET = 2'h3; // set (inverted pwm)

  // tick source stopped
  localparam logic [2:0] SRC_STOPPED = 3'h0;
endpackage : etc_pkg

`default_nettype wire

// [core/etc_tick_sel.sv]
// tick source selection for the timer
// assumes the crystal pin and prescale tick are synchronous to clock
`default_nettype none

module etc_tick_sel (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // source choice
  input wire logic async_clock_select,
  input wire logic [2:0] tick_source_field,
  // candidate tick sources
  input wire logic io_clock_tick,
  input wire logic crystal_pin_a,
  // selected tick, one cycle pulse
  output logic timer_tick
);
  typedef struct packed {
    logic xtal_q; // last crystal level for edge finding
  } etc_tick_s;

  etc_tick_s st_q, st_d;

  // ************************************************
  // edge of the crystal oscillator, then choose
  // ************************************************
  // crystal is an ordinary synchronous input, so one flop is enough
  always_comb begin
    st_d = st_q;
    st_d.xtal_q = crystal_pin_a;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // stopped field gates every source
  assign timer_tick = (tick_source_field != etc_pkg::SRC_STOPPED) &&
    (async_clock_select ? (crystal_pin_a && !st_q.xtal_q) : io_clock_tick);
endmodule : etc_tick_sel

`default_nettype wire

// [core/etc_compare.sv]
// compare register with optional double buffer
// assumes writes and tick strobes come from the counter core
`default_nettype none

module etc_compare #(
  parameter int unsigned W = 8 // compare width
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // cpu side
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata,
  // control from the counter
  input wire logic buffered,
  input wire logic update,
  // active compare value
  output logic [W-1:0] compare_value
);
  typedef struct packed {
    logic [W-1:0] act; // value the comparator sees
    logic [W-1:0] buf_v; // cpu-side buffer
  } etc_cmp_s;

  etc_cmp_s st_q, st_d;

  // ************************************************
  // buffer and active copy
  // ************************************************
  always_comb begin
    st_d = st_q;
    if (wr) begin
      st_d.buf_v = wdata;
      if (!buffered) begin
        st_d.act = wdata; // direct path when unbuffered
      end
    end
    // a write in the same cycle as a buffered update goes straight to the active copy
    if (buffered && update) begin
      st_d.act = wr ? wdata : st_q.buf_v;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = buffered ? st_q.buf_v : st_q.act;
  assign compare_value = st_q.act;
endmodule : etc_compare

`default_nettype wire

// [tb/etc_timer_assertions.sv]
// port checker for the eight bit timer with one compare unit
// assumes it is bound onto etc_timer and sees only its ports
`default_nettype none

module etc_timer_chk #(
  parameter int unsigned W = 8 // counter width
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // tick and configuration
  input wire logic io_clock_tick,
  input wire logic async_clock_select,
  input wire logic [2:0] tick_source_field,
  input wire logic [1:0] waveform_mode_field,
  input wire logic [1:0] output_action_field,
  // counter and compare access
  input wire logic count_wr,
  input wire logic [W-1:0] count_wdata,
  input wire logic [W-1:0] count_value,
  input wire logic compare_wr,
  input wire logic [W-1:0] compare_wdata,
  input wire logic [W-1:0] compare_rdata,
  // strobes, flags and interrupts
  input wire logic force_compare_strobe,
  input wire logic compare_irq_enable,
  input wire logic compare_flag_w1c,
  input wire logic overflow_flag_w1c,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic compare_match_flag,
  input wire logic overflow_flag,
  input wire logic compare_irq,
  // status and pin
  input wire logic count_top,
  input wire logic count_bottom,
  input wire logic port_value,
  input wire logic port_dir,
  input wire logic pin_out,
  input wire logic pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // sequences
  // ************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // a tick from the prescaled source
  sequence s_tick;
    !async_clock_select && tick_source_field != 3'h0 && io_clock_tick;
  endsequence
  // a plain normal-mode step, no write in the way
  sequence s_norm_tick;
    s_tick ##0 (waveform_mode_field == 2'h0 && !count_wr);
  endsequence

  // ************************************************
  // assertions
  // ************************************************
  stop_hold_a: assert property (tick_source_field == 3'h0 && !count_wr |=>
    $stable(count_value)) else $error("counter moved while stopped");
  write_wins_a: assert property (count_wr |=> count_value == $past(count_wdata))
    else $error("counter write lost");
  norm_step_a: assert property (s_norm_tick |=> count_value == $past(count_value) + 1'b1)
    else $error("normal mode step wrong");
  wrap_ovf_a: assert property (s_norm_tick ##0 count_value == 8'hff |=>
    overflow_flag && count_value == 8'h00) else $error("wrap without overflow");
  ovf_sticky_a: assert property (overflow_flag && !overflow_flag_w1c && !overflow_irq_ack
    |=> overflow_flag) else $error("overflow flag dropped");
  top_bottom_a: assert property (count_top == (count_value == 8'hff)
    && count_bottom == (count_value == 8'h00)) else $error("extreme indication wrong");
  irq_gate_a: assert property (compare_irq == (compare_match_flag && compare_irq_enable))
    else $error("compare request wrong");
  flag_clear_a: assert property ((compare_flag_w1c || compare_irq_ack) && !async_clock_select
    && !io_clock_tick |=> !compare_match_flag) else $error("flag not cleared");
  force_noflag_a: assert property (force_compare_strobe && !compare_match_flag
    && !async_clock_select && !io_clock_tick |=> !compare_match_flag)
    else $error("force set the flag");
  pin_mux_a: assert property (pin_oe == port_dir &&
    (output_action_field != 2'h0 || pin_out == port_value)) else $error("pin mux wrong");
  rdata_direct_a: assert property (!waveform_mode_field[0] && compare_wr |=>
    compare_rdata == $past(compare_wdata)) else $error("direct compare write lost");
  fast_wrap_a: assert property (s_tick ##0 (waveform_mode_field == 2'h3 && !count_wr
    && count_value == 8'hff) |=> count_value == 8'h00 && overflow_flag)
    else $error("fast pwm wrap wrong");
  pc_turn_a: assert property (s_tick ##0 (waveform_mode_field == 2'h1 && !count_wr
    && count_value == 8'hff) |=> count_value == 8'hfe) else $error("dual slope did not turn");
endmodule : etc_timer_chk

bind etc_timer etc_timer_chk #(.W(W)) u_chk (.*);

`default_nettype wire

// [tb/etc_timer_bench.sv]
// self-checking bench for the eight bit timer with one compare unit
// assumes etc_timer and its checker are compiled before this file
`default_nettype none

module etc_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // design signals, all inputs valued at time zero
  // ************************************************
  logic clock = 1'b0, nrst = 1'b0, io_clock_tick = 1'b0, crystal_pin_a = 1'b0;
  logic crystal_pin_b = 1'b0, async_clock_select = 1'b0, count_wr = 1'b0, compare_wr = 1'b0;
  logic [2:0] tick_source_field = 3'h0;
  logic [1:0] waveform_mode_field = 2'h0, output_action_field = 2'h0;
  logic [7:0] count_wdata = 8'h00, compare_wdata = 8'h00, count_value, compare_rdata;
  logic force_compare_strobe = 1'b0, compare_irq_enable = 1'b0, overflow_irq_enable = 1'b0;
  logic compare_flag_w1c = 1'b0, overflow_flag_w1c = 1'b0, compare_irq_ack = 1'b0;
  logic overflow_irq_ack = 1'b0, port_value = 1'b0, port_dir = 1'b0;
  logic compare_match_flag, overflow_flag, compare_irq, overflow_irq;
  logic count_top, count_bottom, pin_out, pin_oe;
  // model state and bookkeeping
  logic [7:0] m_cnt, m_cmp, m_buf;
  logic m_cf, m_of, m_oc, m_blk, m_mp, m_prev, m_dn;
  logic [31:0] seed = 32'h0000a2d7;
  int errors = 0, n_compared = 0;

  etc_timer u_dut (.*);

  // 25 MHz clock
  always #20 clock = ~clock;

  // xorshift source, fixed seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // next output state for one match
  function automatic logic act(input logic oc, input logic [1:0] a);
    return a == 2'h1 ? !oc : a == 2'h2 ? 1'b0 : a == 2'h3 ? 1'b1 : oc;
  endfunction : act

  // ************************************************
  // reference model, steps on the same edge as the design
  // ************************************************
  always @(posedge clock) begin : model
    logic tk, mt, pwm, dn, ld, ov;
    if (!nrst) begin
      {m_cnt, m_cmp, m_buf} = '0;
      {m_cf, m_of, m_oc, m_blk, m_mp, m_prev, m_dn} = '0;
    end else begin
      pwm = waveform_mode_field[0];
      tk = tick_source_field != 3'h0 &&
        (async_clock_select ? crystal_pin_a && !m_prev : io_clock_tick);
      m_prev = crystal_pin_a;
      mt = tk && m_cnt == m_cmp && !m_blk;
      // dual slope turns at max and again at bottom
      dn = m_cnt == 8'hff || (m_dn && m_cnt != 8'h00);
      ld = tk && pwm && m_cnt == 8'hff;
      ov = tk && (waveform_mode_field == 2'h1 ? m_dn && m_cnt == 8'h00 : m_cnt == 8'hff);
      if (tk && m_mp) m_cf = 1'b1;
      else if (compare_flag_w1c || compare_irq_ack) m_cf = 1'b0;
      if (ov) m_of = 1'b1;
      else if (overflow_flag_w1c || overflow_irq_ack) m_of = 1'b0;
      if (tk) m_mp = mt;
      // pwm polarity on a match; force shares the plain match path
      if (mt && pwm && output_action_field[1])
        m_oc = output_action_field[0] ^ (waveform_mode_field == 2'h1 && dn);
      else if ((mt || (force_compare_strobe && !pwm)) && waveform_mode_field != 2'h1)
        m_oc = act(m_oc, output_action_field);
      else if (tk && waveform_mode_field == 2'h3 && m_cnt == 8'hff && output_action_field[1])
        m_oc = !output_action_field[0];
      if (tk) begin
        m_blk = 1'b0;
        m_dn = waveform_mode_field == 2'h1 && dn;
        case (waveform_mode_field)
          2'h1: m_cnt = dn ? m_cnt - 8'h01 : m_cnt + 8'h01;
          2'h2: m_cnt = m_cnt == m_cmp ? 8'h00 : m_cnt + 8'h01;
          default: m_cnt = m_cnt + 8'h01;
        endcase
      end
      if (count_wr) begin
        m_cnt = count_wdata;
        m_blk = 1'b1;
      end
      if (compare_wr) m_buf = compare_wdata;
      if (compare_wr && !pwm) m_cmp = compare_wdata;
      if (ld) m_cmp = compare_wr ? compare_wdata : m_buf;
    end
  end

  // ************************************************
  // comparison
  // ************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // outputs settled mid-cycle
  always @(negedge clock) begin
    if (nrst) begin
      chk(count_value, m_cnt);
      chk(compare_rdata, waveform_mode_field[0] ? m_buf : m_cmp);
      chk({7'h0, compare_match_flag}, {7'h0, m_cf});
      chk({7'h0, overflow_flag}, {7'h0, m_of});
      chk({6'h0, overflow_irq, compare_irq},
          {6'h0, m_of && overflow_irq_enable, m_cf && compare_irq_enable});
      chk({6'h0, pin_oe, pin_out}, {6'h0, port_dir, output_action_field != 2'h0 ? m_oc : port_value});
    end
  end

  // one random phase; counter writes and forces kept off tick cycles
  task automatic phase(input string nm, input logic [1:0] md, input logic as,
                       input logic [2:0] src, input int n, input logic wr_ok);
    logic [31:0] r, s;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      s = rnd();
      waveform_mode_field <= md;
      async_clock_select <= as;
      tick_source_field <= src;
      io_clock_tick <= r[0];
      crystal_pin_a <= as & r[1];
      count_wr <= wr_ok && !r[0] && r[7:2] == 6'h0 && r[15:8] != m_cmp;
      count_wdata <= r[15:8];
      compare_wr <= i == 0 || r[21:16] == 6'h1;
      compare_wdata <= md == 2'h2 ? {4'h0, r[27:24]} : r[31:24];
      force_compare_strobe <= !as && !r[0] && s[4:0] == 5'h0;
      compare_flag_w1c <= s[9:5] == 5'h0;
      compare_irq_ack <= s[14:10] == 5'h0;
      overflow_flag_w1c <= s[19:15] == 5'h0;
      overflow_irq_ack <= s[24:20] == 5'h1;
      compare_irq_enable <= s[25];
      overflow_irq_enable <= s[26];
      port_value <= s[27];
      port_dir <= s[28];
      if (s[31:29] == 3'h0) output_action_field <= r[29:28];
      @(posedge clock);
    end
    $display("test %s done", nm);
  endtask : phase

  // final report, the single end of the run
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    repeat (5) @(posedge clock);
    phase("normal", 2'h0, 1'b0, 3'h1, 3000, 1'b1);
    phase("stopped", 2'h0, 1'b0, 3'h0, 300, 1'b1);
    phase("clear_on_match", 2'h2, 1'b0, 3'h2, 2000, 1'b0);
    phase("fast_pwm_held", 2'h3, 1'b0, 3'h0, 200, 1'b0);
    phase("phase_pwm_held", 2'h1, 1'b0, 3'h0, 200, 1'b0);
    phase("fast_pwm", 2'h3, 1'b0, 3'h4, 2500, 1'b0);
    phase("phase_pwm", 2'h1, 1'b0, 3'h4, 2500, 1'b0);
    phase("crystal", 2'h0, 1'b1, 3'h3, 2000, 1'b0);
    phase("normal_again", 2'h0, 1'b0, 3'h5, 1000, 1'b1);
    tally_and_finish();
  end
endmodule : etc_timer_bench

`default_nettype wire
